// File: pkg/tcw_if.sv
/*
  Carrier between the lookup engine, the segment comparator and the tag
  decoder. Assumes all three run on the engine's clock.
*/
interface tcw_if
  import tcw_pkg::*;
#(
  parameter int unsigned AW = 10
);
  logic [ENT_W-1:0] ent_data;
  logic [ENT_W-1:0] ent_mask;
  logic [ENT_W-1:0] key_seg;
  logic [AW-1:0]    base;
  logic             seg_match;
  logic             start_ok;
  logic [SZL_W-1:0] size_log;

  modport eng  (output ent_data, ent_mask, key_seg, base,
                input  seg_match, start_ok, size_log);
  modport cmp  (input ent_data, ent_mask, key_seg, output seg_match);
  modport tag  (input ent_data, ent_mask, base, output start_ok, size_log);
endinterface : tcw_if

// File: pkg/tcw_pkg.sv
/*
  Constants, types and shared decoding for the wide-rule ternary match
  memory. Assumes a single clock domain and software that follows the
  programming discipline below.
*/
// Function
// R1: Software clears every address before lookups
// R2: Unmatched keys take the supplied default rule
// R3: Wide items written one address at a time
// R4: Rule size is larger of entry, action
// R5: Entry and action share start address
// R6: Software disables or zeroes surplus addresses
// R7: Xn rules start on multiples of n
// R8: Moves keep every rule aligned
// R9: Hit increments only offset zero counter
// R10: Software writes highest address first
// R11: Disable lowest first; range fill ascends
// R12: Type-group tag present for multi-size classifier
// R13: Tag sits in lowest bits of address
// R14: Entry tag exact-match, mask bits zero
// R15: Action tag in lowest action bits
// R16: Counters carry no tag
// R17: 1024 addresses, 36/36/70/1 bit storage
// R18: Entry sizes 1..16, action 1..4
// R19: Offset zero entry tag is one-hot size
// R20: Nonzero entry offsets carry zero tags
// R21: Action tag 1 or 10 at offset zero
// R22: Four-address action tag is 100
// R23: Odd action offsets 0, offset two 00
// R24: Data/mask pair encodes 0, any, 1, never
// R25: Wide rule hits only if all segments match
package tcw_pkg;

  localparam int unsigned DEPTH_DEF = 1024; // R17
  localparam int unsigned ENT_W     = 36;
  localparam int unsigned ACT_W     = 70;
  localparam int unsigned CNT_W     = 1;
  localparam int unsigned MAX_SEG   = 16;
  localparam int unsigned KEY_W     = MAX_SEG * ENT_W;
  localparam int unsigned ETAG_W    = 5;
  localparam int unsigned ATAG_W    = 3;
  localparam int unsigned SZL_W     = 3;
  localparam int unsigned OFF_W     = 4;
  localparam int unsigned DEF_W     = 5;

  typedef enum logic [1:0]
  {
    TCW_OP_WRITE = 2'h0,
    TCW_OP_READ  = 2'h1,
    TCW_OP_INIT  = 2'h2
  } tcw_op_t;

  typedef enum logic [2:0]
  {
    TCW_ST_IDLE = 3'h1,
    TCW_ST_INIT = 3'h2,
    TCW_ST_SCAN = 3'h4
  } tcw_state_t;

  // Lowest set bit of a one-hot size tag; bit 3 flags a valid tag
  function automatic logic [3:0] tcw_onehot_log(input logic [ETAG_W-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = ETAG_W - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction : tcw_onehot_log

endpackage : tcw_pkg

// File: tb/tcw_props.sv
/*
  Checker on the ports of the wide-rule match memory top.
  Assumes one clock domain and binding to every tcw_top.
*/
module tcw_props
  import tcw_pkg::*;
#(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4
)(
  // Clock and reset
  input wire logic             clk_sys,
  input wire logic             nrst,
  // Commands
  input wire logic             cmd_valid,
  input wire logic             cmd_ready,
  input wire tcw_op_t          cmd_op,
  input wire logic [AW-1:0]    cmd_addr,
  input wire logic [AW-1:0]    cmd_last,
  input wire logic             rd_valid,
  // Lookup
  input wire logic             key_valid,
  input wire logic             key_ready,
  input wire logic             res_valid,
  input wire logic             res_hit,
  input wire logic [AW-1:0]    res_addr,
  input wire logic [SZL_W-1:0] res_size_log,
  input wire logic [ACT_W-1:0] res_action,
  input wire logic [DEF_W-1:0] res_default_idx
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  logic [AW:0] busy_r;
  logic [AW:0] busy_nxt;
  logic        rd_take;

  assign rd_take = cmd_valid && cmd_ready && cmd_op == TCW_OP_READ;

  always_comb
  begin
    busy_nxt = (busy_r != '0) ? busy_r - 1'b1 : busy_r;
    if (cmd_valid && cmd_ready && cmd_op == TCW_OP_INIT)
    begin
      busy_nxt = (cmd_last < cmd_addr) ? (AW+1)'(1) :
                 {1'b0, cmd_last} - {1'b0, cmd_addr} + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      busy_r <= '0;
    else
      busy_r <= busy_nxt;
  end

  sequence s_key_take;
    key_valid && key_ready;
  endsequence
  sequence s_rd_take;
    cmd_valid && cmd_ready && cmd_op == TCW_OP_READ;
  endsequence

  a_fill_busy: assert property (busy_r != '0 |-> !cmd_ready)
    else $error("range fill let a command in");
  a_fill_done: assert property (busy_r == 1 |=> cmd_ready)
    else $error("range fill did not end on time");
  a_read_answer: assert property (s_rd_take |=> rd_valid)
    else $error("read gave no data");
  a_read_cause: assert property (rd_valid |-> $past(rd_take))
    else $error("read data without a read");
  a_key_bound: assert property (s_key_take |-> ##[2:100] res_valid)
    else $error("lookup gave no result");
  a_key_busy: assert property (s_key_take |=> !key_ready && !cmd_ready)
    else $error("engine not busy in scan");
  a_res_pulse: assert property (res_valid |=> !res_valid)
    else $error("result pulse too long");
  a_default_zero: assert property (res_valid && !res_hit |->
    res_addr == '0 && res_action == '0)
    else $error("default result not clean");
  a_hit_aligned: assert property (res_valid && res_hit |->
    (res_addr & ((AW'(1) << res_size_log) - AW'(1))) == '0)
    else $error("hit at unaligned start");
  a_size_range: assert property (res_valid && res_hit |->
    res_size_log <= 3'h4)
    else $error("rule size out of range");
  a_idx_hold: assert property (res_valid && res_hit |->
    $stable(res_default_idx))
    else $error("default index moved on hit");
endmodule : tcw_props

bind tcw_top tcw_props #(.DEPTH(DEPTH), .AW(AW)) u_props
(
  .clk_sys, .nrst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr,
  .cmd_last, .rd_valid, .key_valid, .key_ready, .res_valid, .res_hit,
  .res_addr, .res_size_log, .res_action, .res_default_idx
);

// File: tb/testbench.sv
/*
  Self-checking bench for the wide-rule match memory.
  Assumes a 16-address instance and the bound port checker.
*/
module testbench
  import tcw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned AW = 4;

  logic             clk_sys, nrst, cmd_valid, cmd_ready, rd_valid;
  tcw_op_t          cmd_op;
  logic [AW-1:0]    cmd_addr, cmd_last, res_addr;
  logic [ENT_W-1:0] cache_entry_data, cache_entry_mask;
  logic [ENT_W-1:0] rd_entry_data, rd_entry_mask;
  logic [ACT_W-1:0] cache_action_data, rd_action_data, res_action;
  logic [CNT_W-1:0] cache_counter, rd_counter;
  logic             lookup_en, key_valid, key_ready, res_valid, res_hit;
  logic [KEY_W-1:0] key_data;
  logic [DEF_W-1:0] key_default_idx, res_default_idx, last_di;
  logic [SZL_W-1:0] res_size_log;
  logic [ENT_W-1:0] md[16], mm[16];
  logic [ACT_W-1:0] ma[16];
  logic [CNT_W-1:0] mc[16];
  logic [82:0]      q_res[$], er;
  logic [142:0]     q_rd[$], ed;
  logic [79:0]      sr;
  logic [31:0]      seed = 32'h401C;
  int               n_mismatch = 0, samples_checked = 0;

  tcw_top #(.DEPTH(16)) dut
  (
    .clk_sys, .nrst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr,
    .cmd_last, .cache_entry_data, .cache_entry_mask, .cache_action_data,
    .cache_counter, .rd_valid, .rd_entry_data, .rd_entry_mask,
    .rd_action_data, .rd_counter, .lookup_en, .key_valid, .key_ready,
    .key_data, .key_default_idx, .res_valid, .res_hit, .res_addr,
    .res_size_log, .res_action, .res_default_idx
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [95:0] rnd();
    logic [95:0] v;
    for (int i = 0; i < 3; i++)
    begin
      seed = lfsr(seed);
      v[i*32 +: 32] = seed;
    end
    return v;
  endfunction : rnd

  function automatic logic [KEY_W-1:0] key2(input logic [35:0] s0, s1);
    logic [KEY_W-1:0] k;
    for (int i = 0; i < KEY_W / 32; i++)
    begin
      seed = lfsr(seed);
      k[i*32 +: 32] = seed;
    end
    k[71:0] = {s1, s0};
    return k;
  endfunction : key2

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [142:0] seen, input logic [142:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic cmd(input tcw_op_t op, input logic [AW-1:0] a, l,
                     input logic [35:0] d, m, input logic [69:0] x,
                     input logic [0:0] c);
    int n;
    n = 0;
    @(negedge clk_sys);
    {cmd_valid, cmd_addr, cmd_last} = {1'b1, a, l};
    cmd_op = op;
    {cache_entry_data, cache_entry_mask} = {d, m};
    {cache_action_data, cache_counter} = {x, c};
    while (cmd_ready !== 1'b1 && n < 100)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 100)
    begin
      n_mismatch++;
      stop_test();
    end
    @(posedge clk_sys);
    if (op == TCW_OP_WRITE)
      {md[a], mm[a], ma[a], mc[a]} = {d, m, x, c};
    if (op == TCW_OP_READ)
      q_rd.push_back({md[a], mm[a], ma[a], mc[a]});
    for (int i = a; op == TCW_OP_INIT && i <= l; i++)
      {md[i], mm[i], ma[i], mc[i]} = {d, m, x, c};
  endtask : cmd

  task automatic wr(input logic [AW-1:0] a, input logic [35:0] d, m,
                    input logic [69:0] x);
    cmd(TCW_OP_WRITE, a, '0, d, m, x, 1'b0);
  endtask : wr

  task automatic rd(input int a);
    cmd(TCW_OP_READ, AW'(a), '0, '0, '0, '0, 1'b0);
  endtask : rd

  task automatic idle();
    @(negedge clk_sys);
    cmd_valid = 1'b0;
  endtask : idle

  task automatic look(input logic [KEY_W-1:0] k, input logic hit,
                      input logic [AW-1:0] a, input logic [2:0] s);
    int n;
    logic [DEF_W-1:0] di;
    n = 0;
    di = DEF_W'(rnd());
    @(negedge clk_sys);
    {key_valid, key_data, key_default_idx} = {1'b1, k, di};
    while (key_ready !== 1'b1 && n < 100)
    begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    if (hit)
      mc[a] = 1'b1;
    else
      last_di = di;
    q_res.push_back({hit, hit ? a : AW'(0), hit ? ma[a] : 70'h0,
                     last_di, s});
    @(negedge clk_sys);
    key_valid = 1'b0;
    while (res_valid !== 1'b1 && n < 200)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 200)
    begin
      n_mismatch++;
      stop_test();
    end
  endtask : look

  always @(negedge clk_sys)
  begin
    if (res_valid === 1'b1)
    begin
      er = q_res.size() ? q_res.pop_front() : 'x;
      sr = {res_hit, res_addr, res_action, res_default_idx};
      chk(143'(sr), 143'(er[82:3]));
      if (er[82])
        chk(143'(res_size_log), 143'(er[2:0]));
    end
    if (rd_valid === 1'b1)
    begin
      ed = q_rd.size() ? q_rd.pop_front() : 'x;
      chk({rd_entry_data, rd_entry_mask,
           rd_action_data, rd_counter}, ed);
    end
  end

  initial
  begin
    logic [95:0]      r, q;
    logic [KEY_W-1:0] kx;
    {nrst, cmd_valid, cmd_addr, cmd_last} = '0;
    cmd_op = TCW_OP_WRITE;
    {cache_entry_data, cache_entry_mask, cache_action_data} = '0;
    {cache_counter, lookup_en, key_valid, key_data} = '0;
    {key_default_idx, last_di} = '0;
    repeat (5) @(negedge clk_sys);
    nrst = 1'b1;
    cmd(TCW_OP_INIT, 4'h0, 4'hF, '1, '1, '0, 1'b0);
    for (int i = 0; i < 16; i++)
      rd(i);
    idle();
    lookup_en = 1'b1;
    look(key2(36'h0, 36'h0), 1'b0, 4'h0, 3'h0);
    r = rnd();
    q = rnd();
    wr(4'h3, {r[34:0], 1'h1} & ~36'h0F0, 36'h0F0,
       {q[68:0], 1'h1});
    idle();
    look(key2(md[3] ^ 36'h050, 36'h0), 1'b1, 4'h3, 3'h0);
    look(key2(md[3], 36'h0), 1'b1, 4'h3, 3'h0);
    r = rnd();
    wr(4'h9, {r[34:0], 1'h0}, '0, {q[68:0], 1'h0});
    wr(4'h8, {r[69:36], 2'h2}, '0, {q[95:28], 2'h2});
    idle();
    kx = key2(md[8], md[9]);
    look(kx, 1'b1, 4'h8, 3'h1);
    look(key2(md[8], md[9] ^ 36'h200), 1'b0, 4'h0, 3'h0);
    rd(3);
    rd(8);
    rd(9);
    r = rnd();
    wr(4'hD, '1, '1, {q[68:0], 1'h0});
    wr(4'hC, {r[34:0], 1'h1}, '0, {q[66:0], 3'h4});
    idle();
    look(key2(md[12], 36'h0), 1'b1, 4'hC, 3'h2);
    r = rnd();
    wr(4'h6, {r[34:0], 1'h0}, '0, '0);
    wr(4'h5, {r[69:36], 2'h2}, '0, '0);
    idle();
    look(key2(md[5], md[6]), 1'b0, 4'h0, 3'h0);
    wr(4'h1, {r[34:0], 1'h1} | 36'h080, 36'h080, '0);
    idle();
    look(key2(md[1], 36'h0), 1'b0, 4'h0, 3'h0);
    cmd(TCW_OP_INIT, 4'h8, 4'h9, '1, '1, '0, 1'b0);
    idle();
    look(kx, 1'b0, 4'h0, 3'h0);
    rd(9);
    wr(4'hB, kx[71:36], '0, {q[68:0], 1'h0});
    wr(4'hA, kx[35:0], '0, {q[95:28], 2'h2});
    idle();
    look(kx, 1'b1, 4'hA, 3'h1);
    idle();
    repeat (4) @(negedge clk_sys);
    chk(143'(q_res.size() + q_rd.size()), 143'(0));
    stop_test();
  end
endmodule : testbench

// File: verilog/tcw_match_cell.sv
/*
  Ternary compare of one stored address against one key segment.
  Assumes data and mask come straight from storage.
*/
module tcw_match_cell
  import tcw_pkg::*;
(
  // Segment under test
  tcw_if.cmp m
);
  logic [ENT_W-1:0] bit_ok;

  genvar i;
  generate
    for (i = 0; i < ENT_W; i++)
    begin : g_bit
      // Mask set: any when data 0, never when data 1
      assign bit_ok[i] = m.ent_mask[i] ? ~m.ent_data[i]
                                       : (m.ent_data[i] == m.key_seg[i]); // R24
    end
  endgenerate

  assign m.seg_match = &bit_ok; // R25

endmodule : tcw_match_cell

// File: verilog/tcw_tag_decode.sv
/*
  Decodes the offset-zero size tag of an entry and checks that the
  address is a legal start for that size. Assumes a one-hot tag.
*/
module tcw_tag_decode
  import tcw_pkg::*;
#(
  parameter int unsigned AW = 10
)(
  // Stored address and its position
  tcw_if.tag t
);
  logic [3:0]    dec;
  logic          mask_bad;
  logic [AW-1:0] align_mask;

  always_comb
  begin
    dec      = tcw_onehot_log(t.ent_data[ETAG_W-1:0]); // R12 R13 R19
    mask_bad = 1'b0;
    for (int i = 0; i < ETAG_W; i++)
    begin
      if ((3'(i) <= dec[2:0]) && t.ent_mask[i])
      begin
        mask_bad = 1'b1; // R14
      end
    end
    align_mask = ~({AW{1'b1}} << dec[2:0]);
  end

  assign t.size_log = dec[2:0]; // R18
  assign t.start_ok = dec[3] & ~mask_bad & ((t.base & align_mask) == '0); // R7

endmodule : tcw_tag_decode

// File: verilog/tcw_top.sv
/*
  Wide-rule ternary match memory: storage, cache access, range fill and
  key lookup with hit counting. Assumes software initialises storage and
  programs tags, alignment and write order before enabling lookups.
*/
module tcw_top
  import tcw_pkg::*;
#(
  parameter int unsigned DEPTH = DEPTH_DEF,
  parameter int unsigned AW    = $clog2(DEPTH)
)(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // Cache command port
  input  wire logic             cmd_valid,
  output      logic             cmd_ready,
  input  wire tcw_op_t          cmd_op,
  input  wire logic [AW-1:0]    cmd_addr,
  input  wire logic [AW-1:0]    cmd_last,
  input  wire logic [ENT_W-1:0] cache_entry_data,
  input  wire logic [ENT_W-1:0] cache_entry_mask,
  input  wire logic [ACT_W-1:0] cache_action_data,
  input  wire logic [CNT_W-1:0] cache_counter,
  // Read-back
  output      logic             rd_valid,
  output      logic [ENT_W-1:0] rd_entry_data,
  output      logic [ENT_W-1:0] rd_entry_mask,
  output      logic [ACT_W-1:0] rd_action_data,
  output      logic [CNT_W-1:0] rd_counter,
  // Lookup request
  input  wire logic             lookup_en,
  input  wire logic             key_valid,
  output      logic             key_ready,
  input  wire logic [KEY_W-1:0] key_data,
  input  wire logic [DEF_W-1:0] key_default_idx,
  // Lookup result
  output      logic             res_valid,
  output      logic             res_hit,
  output      logic [AW-1:0]    res_addr,
  output      logic [SZL_W-1:0] res_size_log,
  output      logic [ACT_W-1:0] res_action,
  output      logic [DEF_W-1:0] res_default_idx
);

  // Storage, contents undefined until software fills it
  logic [ENT_W-1:0] ent_mem_r [DEPTH];
  logic [ENT_W-1:0] msk_mem_r [DEPTH];
  logic [ACT_W-1:0] act_mem_r [DEPTH];
  logic [CNT_W-1:0] cnt_mem_r [DEPTH];

  // Engine state
  tcw_state_t       state_r, state_nxt;
  logic [AW-1:0]    base_r, base_nxt;
  logic [AW-1:0]    end_r, end_nxt;
  logic [OFF_W-1:0] off_r, off_nxt;
  logic [SZL_W-1:0] sz_r, sz_nxt;
  logic [KEY_W-1:0] key_r, key_nxt;
  logic [DEF_W-1:0] dflt_r, dflt_nxt;
  logic [ENT_W-1:0] c_ent_r, c_ent_nxt;
  logic [ENT_W-1:0] c_msk_r, c_msk_nxt;
  logic [ACT_W-1:0] c_act_r, c_act_nxt;
  logic [CNT_W-1:0] c_cnt_r, c_cnt_nxt;

  // Output registers
  logic             rd_valid_r, rd_valid_nxt;
  logic [ENT_W-1:0] rd_ent_r, rd_ent_nxt;
  logic [ENT_W-1:0] rd_msk_r, rd_msk_nxt;
  logic [ACT_W-1:0] rd_act_r, rd_act_nxt;
  logic [CNT_W-1:0] rd_cnt_r, rd_cnt_nxt;
  logic             res_valid_r, res_valid_nxt;
  logic             res_hit_r, res_hit_nxt;
  logic [AW-1:0]    res_addr_r, res_addr_nxt;
  logic [SZL_W-1:0] res_sz_r, res_sz_nxt;
  logic [ACT_W-1:0] res_act_r, res_act_nxt;
  logic [DEF_W-1:0] res_dflt_r, res_dflt_nxt;

  // Storage write port
  logic             wr_en;
  logic [AW-1:0]    wr_idx;
  logic [ENT_W-1:0] wr_ent;
  logic [ENT_W-1:0] wr_msk;
  logic [ACT_W-1:0] wr_act;
  logic [CNT_W-1:0] wr_cnt;
  logic             cnt_we;
  logic [CNT_W-1:0] cnt_new;

  // Scan helpers
  logic [AW:0]      idx_w;
  logic [AW-1:0]    idx_a;
  logic             in_range;
  logic             seg_ok;
  logic [OFF_W-1:0] last_off;
  logic [SZL_W-1:0] ent_sz;
  logic [3:0]       act_dec;
  logic [SZL_W-1:0] rule_sz;

  tcw_if #(.AW(AW)) m_if ();

  tcw_match_cell u_cell
  (
    .m (m_if.cmp)
  );

  tcw_tag_decode #(.AW(AW)) u_tag
  (
    .t (m_if.tag)
  );

  assign idx_w    = {1'b0, base_r} + (AW+1)'(off_r);
  assign idx_a    = idx_w[AW-1:0];
  assign in_range = idx_w < (AW+1)'(DEPTH);

  assign m_if.ent_data = ent_mem_r[idx_a];
  assign m_if.ent_mask = msk_mem_r[idx_a];
  assign m_if.key_seg  = key_r[off_r*ENT_W +: ENT_W];
  assign m_if.base     = base_r;
  assign seg_ok        = in_range & m_if.seg_match; // R25

  assign ent_sz   = (off_r == '0) ? m_if.size_log : sz_r;
  assign last_off = OFF_W'((5'h01 << sz_r) - 5'h01);
  assign act_dec  = tcw_onehot_log({2'h0, act_mem_r[base_r][ATAG_W-1:0]});
  assign rule_sz  = (act_dec[3] && act_dec[2:0] > ent_sz)
                    ? act_dec[2:0] : ent_sz; // R4
  // Saturating hit count, no tag bits in the counter
  assign cnt_new  = (&cnt_mem_r[base_r]) ? cnt_mem_r[base_r]
                                         : cnt_mem_r[base_r] + CNT_W'(1); // R16

  assign cmd_ready = (state_r == TCW_ST_IDLE);
  assign key_ready = (state_r == TCW_ST_IDLE) & lookup_en & ~cmd_valid;

  always_comb
  begin
    state_nxt     = state_r;
    base_nxt      = base_r;
    end_nxt       = end_r;
    off_nxt       = off_r;
    sz_nxt        = sz_r;
    key_nxt       = key_r;
    dflt_nxt      = dflt_r;
    c_ent_nxt     = c_ent_r;
    c_msk_nxt     = c_msk_r;
    c_act_nxt     = c_act_r;
    c_cnt_nxt     = c_cnt_r;
    rd_valid_nxt  = 1'b0;
    rd_ent_nxt    = rd_ent_r;
    rd_msk_nxt    = rd_msk_r;
    rd_act_nxt    = rd_act_r;
    rd_cnt_nxt    = rd_cnt_r;
    res_valid_nxt = 1'b0;
    res_hit_nxt   = res_hit_r;
    res_addr_nxt  = res_addr_r;
    res_sz_nxt    = res_sz_r;
    res_act_nxt   = res_act_r;
    res_dflt_nxt  = res_dflt_r;
    wr_en         = 1'b0;
    wr_idx        = cmd_addr;
    wr_ent        = cache_entry_data;
    wr_msk        = cache_entry_mask;
    wr_act        = cache_action_data;
    wr_cnt        = cache_counter;
    cnt_we        = 1'b0;
    case (state_r)
      TCW_ST_IDLE:
      begin
        if (cmd_valid)
        begin
          case (cmd_op)
            TCW_OP_WRITE:
            begin
              wr_en = 1'b1; // R3
            end
            TCW_OP_READ:
            begin
              rd_valid_nxt = 1'b1;
              rd_ent_nxt   = ent_mem_r[cmd_addr];
              rd_msk_nxt   = msk_mem_r[cmd_addr];
              rd_act_nxt   = act_mem_r[cmd_addr];
              rd_cnt_nxt   = cnt_mem_r[cmd_addr];
            end
            TCW_OP_INIT:
            begin
              c_ent_nxt = cache_entry_data;
              c_msk_nxt = cache_entry_mask;
              c_act_nxt = cache_action_data;
              c_cnt_nxt = cache_counter;
              base_nxt  = cmd_addr;
              end_nxt   = cmd_last;
              state_nxt = TCW_ST_INIT;
            end
            default:
            begin
              wr_en = 1'b0;
            end
          endcase
        end
        else if (key_valid && lookup_en)
        begin
          key_nxt   = key_data;
          dflt_nxt  = key_default_idx;
          base_nxt  = '0;
          off_nxt   = '0;
          state_nxt = TCW_ST_SCAN;
        end
      end
      TCW_ST_INIT:
      begin
        // Ascending fill disables a rule's lowest address first
        wr_en  = 1'b1; // R11
        wr_idx = base_r;
        wr_ent = c_ent_r;
        wr_msk = c_msk_r;
        wr_act = c_act_r;
        wr_cnt = c_cnt_r;
        if (base_r >= end_r || base_r == AW'(DEPTH - 1))
        begin
          state_nxt = TCW_ST_IDLE;
        end
        else
        begin
          base_nxt = base_r + AW'(1);
        end
      end
      TCW_ST_SCAN:
      begin
        if (seg_ok && (off_r != '0 || m_if.start_ok)
            && (off_r == '0 ? m_if.size_log == '0 : off_r == last_off))
        begin
          // Whole rule matched; lowest address wins
          cnt_we        = 1'b1; // R9
          res_valid_nxt = 1'b1;
          res_hit_nxt   = 1'b1;
          res_addr_nxt  = base_r;
          res_sz_nxt    = rule_sz;
          res_act_nxt   = act_mem_r[base_r];
          state_nxt     = TCW_ST_IDLE;
        end
        else if (seg_ok && (off_r != '0 || m_if.start_ok))
        begin
          if (off_r == '0)
          begin
            sz_nxt = m_if.size_log;
          end
          off_nxt = off_r + OFF_W'(1); // R25
        end
        else if (base_r == AW'(DEPTH - 1))
        begin
          // No entry matched: the default rule applies
          res_valid_nxt = 1'b1; // R2
          res_hit_nxt   = 1'b0;
          res_addr_nxt  = '0;
          res_sz_nxt    = '0;
          res_act_nxt   = '0;
          res_dflt_nxt  = dflt_r;
          state_nxt     = TCW_ST_IDLE;
        end
        else
        begin
          base_nxt = base_r + AW'(1);
          off_nxt  = '0;
        end
      end
      default:
      begin
        state_nxt = TCW_ST_IDLE;
      end
    endcase
  end

  // Storage has no reset
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      ent_mem_r[wr_idx] <= wr_ent;
      msk_mem_r[wr_idx] <= wr_msk;
      act_mem_r[wr_idx] <= wr_act;
      cnt_mem_r[wr_idx] <= wr_cnt;
    end
    if (cnt_we)
    begin
      cnt_mem_r[base_r] <= cnt_new; // R9
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r     <= TCW_ST_IDLE;
      base_r      <= '0;
      end_r       <= '0;
      off_r       <= '0;
      sz_r        <= '0;
      key_r       <= '0;
      dflt_r      <= '0;
      c_ent_r     <= '0;
      c_msk_r     <= '0;
      c_act_r     <= '0;
      c_cnt_r     <= '0;
      rd_valid_r  <= 1'b0;
      rd_ent_r    <= '0;
      rd_msk_r    <= '0;
      rd_act_r    <= '0;
      rd_cnt_r    <= '0;
      res_valid_r <= 1'b0;
      res_hit_r   <= 1'b0;
      res_addr_r  <= '0;
      res_sz_r    <= '0;
      res_act_r   <= '0;
      res_dflt_r  <= '0;
    end
    else
    begin
      state_r     <= state_nxt;
      base_r      <= base_nxt;
      end_r       <= end_nxt;
      off_r       <= off_nxt;
      sz_r        <= sz_nxt;
      key_r       <= key_nxt;
      dflt_r      <= dflt_nxt;
      c_ent_r     <= c_ent_nxt;
      c_msk_r     <= c_msk_nxt;
      c_act_r     <= c_act_nxt;
      c_cnt_r     <= c_cnt_nxt;
      rd_valid_r  <= rd_valid_nxt;
      rd_ent_r    <= rd_ent_nxt;
      rd_msk_r    <= rd_msk_nxt;
      rd_act_r    <= rd_act_nxt;
      rd_cnt_r    <= rd_cnt_nxt;
      res_valid_r <= res_valid_nxt;
      res_hit_r   <= res_hit_nxt;
      res_addr_r  <= res_addr_nxt;
      res_sz_r    <= res_sz_nxt;
      res_act_r   <= res_act_nxt;
      res_dflt_r  <= res_dflt_nxt;
    end
  end

  assign rd_valid        = rd_valid_r;
  assign rd_entry_data   = rd_ent_r;
  assign rd_entry_mask   = rd_msk_r;
  assign rd_action_data  = rd_act_r;
  assign rd_counter      = rd_cnt_r;
  assign res_valid       = res_valid_r;
  assign res_hit         = res_hit_r;
  assign res_addr        = res_addr_r;
  assign res_size_log    = res_sz_r;
  assign res_action      = res_act_r;
  assign res_default_idx = res_dflt_r;

endmodule : tcw_top
